// [core/asb_pkg.sv]
// Shared constants, state types and enumerations of the sample buffer block
package asb_pkg;

	// ********************************
	// Widths
	// ********************************
	localparam int unsigned CH_W = 3;
	localparam int unsigned NUM_CH = 8;
	localparam int unsigned RES_W = 10;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned LEN_W = 11;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned ACC_W = 14;

	// ********************************
	// Limits, reset values and counts
	// ********************************
	localparam logic [15:0] LEN_MIN = 16'h0001;
	localparam logic [15:0] LEN_MAX = 16'h07FF;
	localparam logic [10:0] OFFS_FULL_NOWRAP = 11'h7FF;
	localparam logic [10:0] OFFS_RESET = 11'h000;
	localparam logic [2:0] IRQ_SEL_NONE = 3'h0;
	localparam logic [7:0] SRC_NONE = 8'h00;
	localparam logic [4:0] ACC_BASE = 5'h02;
	localparam logic [4:0] ACC_LAST = 5'h01;
	localparam logic [3:0] CH_FIRST = 4'h0;
	localparam logic [5:0] WORD_PAD = 6'h00;
	localparam logic [1:0] ACC_PAD = 2'h0;

	// ********************************
	// Field positions
	// ********************************
	localparam int IRQ_HALF_BIT = 0;
	localparam int IRQ_FULL_BIT = 1;
	localparam int IRQ_OVER_BIT = 2;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_WAIT_TRIG,
		ST_CONV,
		ST_DMA,
		ST_FULL
	} asb_state_t;

	typedef struct packed {
		logic [10:0] offs;
		logic full;
	} asb_ptr_state_t;

	typedef struct packed {
		asb_state_t st;
		logic [3:0] ch_from;
		logic conv_req;
		logic [2:0] conv_ch;
		logic span;
		logic dma_valid;
		logic [15:0] dma_addr;
		logic [15:0] dma_data;
		logic half_irq;
		logic full_irq;
		logic over_irq;
		logic rej;
		logic active;
		logic busy;
		logic [10:0] offset;
		logic wrap;
		logic [10:0] len;
		logic [15:0] base;
		logic [2:0] irq_sel;
		logic [7:0] bitmap;
		logic acc_mode;
		logic cont;
		logic [13:0] acc_sum;
		logic [4:0] acc_left;
		logic res_valid;
		logic [15:0] result;
	} asb_top_state_t;

endpackage : asb_pkg

// [core/asb_ptr_if.sv]
// Carrier between the sequencing core and the buffer write pointer
`timescale 1ns/1ps
`default_nettype none
interface asb_ptr_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic clr;
	logic adv;
	logic wrap;
	logic [10:0] len;
	logic [10:0] offset;
	logic full_evt;
	logic half_evt;

	modport core (
		input clk,
		input rst_n,
		output clr,
		output adv,
		output wrap,
		output len,
		input offset,
		input full_evt,
		input half_evt
	);

	modport ptr (
		input clk,
		input rst_n,
		input clr,
		input adv,
		input wrap,
		input len,
		output offset,
		output full_evt,
		output half_evt
	);
endinterface : asb_ptr_if
`default_nettype wire

// [core/asb_seq.sv]
// Picks the next enabled input at or above a start index
`timescale 1ns/1ps
`default_nettype none
module asb_seq (
	input wire logic [7:0] bitmap,
	input wire logic [3:0] from_idx,
	output logic found,
	output logic [2:0] next_ch
);
	// ********************************
	// Priority search
	// ********************************
	// (R5) lowest index wins
	always_comb begin
		found = 1'b0;
		next_ch = 3'h0;
		for (int i = asb_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (bitmap[i] && (4'(i) >= from_idx)) begin
				found = 1'b1;
				next_ch = 3'(i);
			end
		end
	end
endmodule : asb_seq
`default_nettype wire

// [core/asb_ptr.sv]
// Write offset counter with half-full, full and wrap handling
`timescale 1ns/1ps
`default_nettype none
module asb_ptr (
	asb_ptr_if.ptr pi
);
	asb_pkg::asb_ptr_state_t q, d;
	logic [10:0] half_tgt;
	logic at_last;

	// ********************************
	// Next state
	// ********************************
	assign at_last = (q.offs == (pi.len - 11'h001));
	// (R15) half point rounded down
	assign half_tgt = ((pi.len >> 1) == 11'h000) ? 11'h001 : (pi.len >> 1);
	assign pi.half_evt = pi.adv && ((q.offs + 11'h001) == half_tgt);
	// (R15) full on last slot
	assign pi.full_evt = pi.adv && at_last;
	// (R14) full without wrap reads top
	assign pi.offset = q.full ? asb_pkg::OFFS_FULL_NOWRAP : q.offs;

	always_comb begin
		d = q;
		if (pi.clr) begin
			d.offs = asb_pkg::OFFS_RESET;
			d.full = 1'b0;
		end else if (pi.adv) begin
			if (at_last) begin
				// (R7) wrap to first slot
				if (pi.wrap) begin
					d.offs = asb_pkg::OFFS_RESET;
				end else begin
					d.full = 1'b1;
				end
			end else begin
				d.offs = q.offs + 11'h001;
			end
		end
	end

	always_ff @(posedge pi.clk or negedge pi.rst_n) begin
		if (!pi.rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ********************************
	// Checks
	// ********************************
	property p_r7;
		@(posedge pi.clk) disable iff (!pi.rst_n)
		(pi.adv && at_last && pi.wrap && !pi.clr) |=> (pi.offset == asb_pkg::OFFS_RESET);
	endproperty
	a_r7: assert property (p_r7) else $error("wrap did not return to slot zero"); // (R7)
endmodule : asb_ptr
`default_nettype wire

// [core/asb_top.sv]
// Converter control with timer-paced sample buffer writes
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Disable stops continuous and accumulation runs
// (R2) Each 10-bit result stored as 16-bit word
// (R3) Buffer mode converts only on timer triggers
// (R4) Every selected input converted once per trigger
// (R5) Order: inputs 0-5, temperature, supply
// (R6) Length 1 to 2047, else start refused
// (R7) Wrap writes next sample at slot zero
// (R8) Without wrap, stop converting when full
// (R9) Raise each selected buffer interrupt condition
// (R10) Overflow flags triggers after buffer filled
// (R11) One span select: Vref or twice Vref
// (R12) Stop command ends buffer mode anytime
// (R13) Next write offset readable in samples
// (R14) Full offset: 2047 no wrap, 0 wrap
// (R15) Half at length/2 rounded down, full last
module asb_top (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic conv_start,
	input wire logic conv_continuous,
	input wire logic [2:0] conv_source,
	input wire logic accum_start,
	input wire logic [1:0] accum_sel,
	input wire logic conv_disable,
	input wire logic sb_start,
	input wire logic sb_stop,
	input wire logic input_span_select,
	input wire logic [7:0] input_select_bitmap,
	input wire logic [15:0] buffer_base_pointer,
	input wire logic [15:0] buffer_length,
	input wire logic wrap_enable,
	input wire logic [2:0] irq_condition_select,
	input wire logic sample_trigger_timer,
	input wire logic conv_done,
	input wire logic [9:0] conv_result,
	input wire logic dma_wr_ready,
	output logic conv_req,
	output logic [2:0] conv_channel,
	output logic conv_span,
	output logic dma_wr_valid,
	output logic [15:0] dma_wr_addr,
	output logic [15:0] dma_wr_data,
	output logic half_full_irq,
	output logic full_irq,
	output logic overflow_irq,
	output logic start_rejected,
	output logic sb_active,
	output logic conv_busy,
	output logic [10:0] next_write_offset,
	output logic result_valid,
	output logic [15:0] result_data
);
	// ********************************
	// Reset release
	// ********************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ********************************
	// Submodules
	// ********************************
	asb_pkg::asb_top_state_t q, d;
	logic sq_found;
	logic [2:0] sq_ch;
	logic [3:0] sq_from;
	logic start_ok;

	asb_ptr_if pi (
		.clk(ref_clk),
		.rst_n(rst_n)
	);

	asb_ptr u_ptr (
		.pi(pi)
	);

	// Search restarts at input 0 for each trigger
	assign sq_from = (q.st == asb_pkg::ST_WAIT_TRIG) ? asb_pkg::CH_FIRST : q.ch_from;

	asb_seq u_seq (
		.bitmap(q.bitmap),
		.from_idx(sq_from),
		.found(sq_found),
		.next_ch(sq_ch)
	);

	// (R6) length range check
	assign start_ok = (buffer_length >= asb_pkg::LEN_MIN) &&
		(buffer_length <= asb_pkg::LEN_MAX) &&
		(irq_condition_select != asb_pkg::IRQ_SEL_NONE) &&
		(input_select_bitmap != asb_pkg::SRC_NONE);

	assign pi.clr = (q.st == asb_pkg::ST_IDLE) && sb_start && start_ok;
	assign pi.adv = (q.st == asb_pkg::ST_DMA) && q.dma_valid && dma_wr_ready;
	assign pi.wrap = q.wrap;
	assign pi.len = q.len;

	// ********************************
	// Control
	// ********************************
	always_comb begin
		d = q;
		d.half_irq = 1'b0;
		d.full_irq = 1'b0;
		d.over_irq = 1'b0;
		d.rej = 1'b0;
		d.res_valid = 1'b0;
		// (R13) next write offset
		d.offset = pi.offset;
		d.busy = (q.st == asb_pkg::ST_RUN) || (q.st == asb_pkg::ST_CONV);
		case (q.st)
			asb_pkg::ST_IDLE: begin
				if (sb_start) begin
					// (R6) refuse bad length
					if (start_ok) begin
						d.st = asb_pkg::ST_WAIT_TRIG;
						d.active = 1'b1;
						d.wrap = wrap_enable;
						d.len = buffer_length[10:0];
						d.base = buffer_base_pointer;
						d.irq_sel = irq_condition_select;
						d.bitmap = input_select_bitmap;
						// (R11) span latched once
						d.span = input_span_select;
					end else begin
						d.rej = 1'b1;
					end
				end else if (conv_start || accum_start) begin
					d.st = asb_pkg::ST_RUN;
					d.conv_req = 1'b1;
					d.conv_ch = conv_source;
					d.span = input_span_select;
					d.acc_mode = accum_start;
					d.cont = conv_continuous;
					d.acc_sum = '0;
					d.acc_left = asb_pkg::ACC_BASE << accum_sel;
				end
			end
			asb_pkg::ST_RUN: begin
				// (R1) disable halts run
				if (conv_disable) begin
					d.st = asb_pkg::ST_IDLE;
					d.conv_req = 1'b0;
				end else if (conv_done) begin
					if (q.acc_mode) begin
						d.acc_sum = q.acc_sum + {4'h0, conv_result};
						d.acc_left = q.acc_left - 5'h01;
						if (q.acc_left == asb_pkg::ACC_LAST) begin
							d.res_valid = 1'b1;
							d.result = {asb_pkg::ACC_PAD, d.acc_sum};
							d.st = asb_pkg::ST_IDLE;
							d.conv_req = 1'b0;
						end
					end else begin
						d.res_valid = 1'b1;
						d.result = {asb_pkg::WORD_PAD, conv_result};
						if (!q.cont) begin
							d.st = asb_pkg::ST_IDLE;
							d.conv_req = 1'b0;
						end
					end
				end
			end
			asb_pkg::ST_WAIT_TRIG: begin
				if (sb_stop) begin
					d.st = asb_pkg::ST_IDLE;
					d.active = 1'b0;
				// (R3) timer paces conversions
				end else if (sample_trigger_timer && sq_found) begin
					d.st = asb_pkg::ST_CONV;
					d.conv_ch = sq_ch;
					d.conv_req = 1'b1;
				end
			end
			asb_pkg::ST_CONV: begin
				if (sb_stop) begin
					d.st = asb_pkg::ST_IDLE;
					d.active = 1'b0;
					d.conv_req = 1'b0;
				end else if (conv_done) begin
					// (R2) result as 16-bit word
					d.st = asb_pkg::ST_DMA;
					d.conv_req = 1'b0;
					d.dma_valid = 1'b1;
					d.dma_data = {asb_pkg::WORD_PAD, conv_result};
					d.dma_addr = q.base + {4'h0, pi.offset, 1'b0};
					d.ch_from = {1'b0, q.conv_ch} + 4'h1;
				end
			end
			asb_pkg::ST_DMA: begin
				// (R12) stop ends mode
				if (sb_stop) begin
					d.st = asb_pkg::ST_IDLE;
					d.active = 1'b0;
					d.dma_valid = 1'b0;
				end else if (dma_wr_ready) begin
					d.dma_valid = 1'b0;
					// (R9) selected conditions only
					d.half_irq = pi.half_evt && q.irq_sel[asb_pkg::IRQ_HALF_BIT];
					d.full_irq = pi.full_evt && q.irq_sel[asb_pkg::IRQ_FULL_BIT];
					// (R8) stop when full
					if (pi.full_evt && !q.wrap) begin
						d.st = asb_pkg::ST_FULL;
					// (R4) next enabled input
					end else if (sq_found) begin
						d.st = asb_pkg::ST_CONV;
						d.conv_ch = sq_ch;
						d.conv_req = 1'b1;
					end else begin
						d.st = asb_pkg::ST_WAIT_TRIG;
					end
				end
			end
			asb_pkg::ST_FULL: begin
				if (sb_stop) begin
					d.st = asb_pkg::ST_IDLE;
					d.active = 1'b0;
				// (R10) late sample overflow
				end else if (sample_trigger_timer) begin
					d.over_irq = q.irq_sel[asb_pkg::IRQ_OVER_BIT];
				end
			end
			default: begin
				d.st = asb_pkg::ST_IDLE;
				d.conv_req = 1'b0;
				d.dma_valid = 1'b0;
				d.active = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign conv_req = q.conv_req;
	assign conv_channel = q.conv_ch;
	assign conv_span = q.span;
	assign dma_wr_valid = q.dma_valid;
	assign dma_wr_addr = q.dma_addr;
	assign dma_wr_data = q.dma_data;
	assign half_full_irq = q.half_irq;
	assign full_irq = q.full_irq;
	assign overflow_irq = q.over_irq;
	assign start_rejected = q.rej;
	assign sb_active = q.active;
	assign conv_busy = q.busy;
	assign next_write_offset = q.offset;
	assign result_valid = q.res_valid;
	assign result_data = q.result;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_r1;
		(q.st == asb_pkg::ST_RUN && conv_disable) |=> (q.st == asb_pkg::ST_IDLE) && !conv_req;
	endproperty
	a_r1: assert property (p_r1) else $error("disable did not halt run"); // (R1)

	property p_r2;
		dma_wr_valid |-> (dma_wr_data[15:10] == asb_pkg::WORD_PAD);
	endproperty
	a_r2: assert property (p_r2) else $error("buffer word upper bits not zero"); // (R2)

	property p_r3;
		(q.st == asb_pkg::ST_WAIT_TRIG && !sample_trigger_timer) |=> !conv_req;
	endproperty
	a_r3: assert property (p_r3) else $error("conversion without timer trigger"); // (R3)

	property p_r5;
		(q.st == asb_pkg::ST_DMA) ##1 (q.st == asb_pkg::ST_CONV) |-> (conv_channel > $past(conv_channel));
	endproperty
	a_r5: assert property (p_r5) else $error("input order not ascending"); // (R5)

	property p_r6;
		(q.st == asb_pkg::ST_IDLE && sb_start &&
			(buffer_length < asb_pkg::LEN_MIN || buffer_length > asb_pkg::LEN_MAX))
		|=> start_rejected && (q.st == asb_pkg::ST_IDLE);
	endproperty
	a_r6: assert property (p_r6) else $error("bad length not refused"); // (R6)

	property p_r8;
		(q.st == asb_pkg::ST_FULL && !sb_stop) |=> (q.st == asb_pkg::ST_FULL) && !conv_req;
	endproperty
	a_r8: assert property (p_r8) else $error("converting after buffer full"); // (R8)

	property p_r10;
		(q.st == asb_pkg::ST_FULL && !sb_stop && sample_trigger_timer &&
			q.irq_sel[asb_pkg::IRQ_OVER_BIT]) |=> overflow_irq;
	endproperty
	a_r10: assert property (p_r10) else $error("overflow not raised"); // (R10)

	property p_r12;
		(sb_stop && sb_active && q.st != asb_pkg::ST_IDLE) |=> (q.st == asb_pkg::ST_IDLE) ##1 !sb_active;
	endproperty
	a_r12: assert property (p_r12) else $error("stop did not end buffer mode"); // (R12)

	property p_r14;
		(q.st == asb_pkg::ST_FULL) [*2] |-> (next_write_offset == asb_pkg::OFFS_FULL_NOWRAP);
	endproperty
	a_r14: assert property (p_r14) else $error("full offset not top value"); // (R14)

endmodule : asb_top
`default_nettype wire

// [sim/asb_ram_model.sv]
// Behavioural RAM that takes the buffer writes
`timescale 1ns/1ps
`default_nettype none
module asb_ram_model (
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic valid,
	input wire logic [15:0] addr,
	input wire logic [15:0] data,
	output logic ready
);
	// ********
	// Storage
	// ********
	logic [15:0] mem [int];
	int n_wr = 0;
	logic [1:0] cnt = 2'h0;
	initial ready = 1'b0;
	always @(posedge ref_clk) begin
		if (valid === 1'b1 && ready === 1'b1) begin
			mem[addr] = data;
			n_wr++;
		end
		cnt <= cnt + 2'h1;
		// Slow mode stalls three cycles of four
		ready <= #1 !slow || cnt == 2'h3;
	end
endmodule : asb_ram_model
`default_nettype wire

// [sim/tb_adc_sample_buffer_dma.sv]
// Self-checking bench of the sample buffer block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sample_buffer_dma;
	// ********
	// Signals
	// ********
	logic ref_clk, resetn = 1'b0, conv_start = 1'b0, conv_continuous = 1'b0, accum_start = 1'b0;
	logic conv_disable = 1'b0, sb_start = 1'b0, sb_stop = 1'b0, input_span_select = 1'b0;
	logic wrap_enable = 1'b0, sample_trigger_timer = 1'b0, conv_done = 1'b0, slow = 1'b0;
	logic [2:0] conv_source = 3'h0, irq_condition_select = 3'h0;
	logic [1:0] accum_sel = 2'h0;
	logic [7:0] input_select_bitmap = 8'h00, bm;
	logic [15:0] buffer_base_pointer = 16'h0000, buffer_length = 16'h0000, base, tmp;
	logic [15:0] cfg, exp16;
	logic [9:0] conv_result = 10'h000;
	logic dma_wr_ready, conv_req, conv_span, dma_wr_valid, half_full_irq, full_irq;
	logic overflow_irq, start_rejected, sb_active, conv_busy, result_valid;
	logic [2:0] conv_channel;
	logic [15:0] dma_wr_addr, dma_wr_data, result_data;
	logic [10:0] next_write_offset;
	logic [15:0] lfsr = 16'hB67F;
	logic [2:0] ch_q [$];
	logic [9:0] res_q [$];
	int fail_count = 0, n_compared = 0, n_half, n_full, n_over, exp_off, exp_from, lenv;
	int cnt = 0, hold = 0, k, w0, n;

	asb_top dut (.ref_clk, .resetn, .conv_start, .conv_continuous, .conv_source, .accum_start,
		.accum_sel, .conv_disable, .sb_start, .sb_stop, .input_span_select, .input_select_bitmap,
		.buffer_base_pointer, .buffer_length, .wrap_enable, .irq_condition_select,
		.sample_trigger_timer, .conv_done, .conv_result, .dma_wr_ready, .conv_req, .conv_channel,
		.conv_span, .dma_wr_valid, .dma_wr_addr, .dma_wr_data, .half_full_irq, .full_irq,
		.overflow_irq, .start_rejected, .sb_active, .conv_busy, .next_write_offset,
		.result_valid, .result_data);
	asb_ram_model ram (.ref_clk, .slow, .valid(dma_wr_valid), .addr(dma_wr_addr),
		.data(dma_wr_data), .ready(dma_wr_ready));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ********
	// Helpers
	// ********
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd

	function automatic logic [2:0] next_ch(input logic [7:0] b, input int from);
		for (int i = from; i < from + 8; i++)
			if (b[i % 8]) return 3'(i % 8);
		return 3'h0;
	endfunction : next_ch

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic pulse(ref logic s);
		@(posedge ref_clk) #1 s = 1'b1;
		@(posedge ref_clk) #1 s = 1'b0;
	endtask : pulse

	task automatic wait_wr(input int w);
		for (int i = 0; i < 500 && ram.n_wr < w; i++) @(posedge ref_clk);
		if (ram.n_wr < w) begin
			fail_count++;
			end_sim();
		end else begin
			repeat (3) @(posedge ref_clk);
			#1;
		end
	endtask : wait_wr

	task automatic sb_go(input logic [15:0] len, input logic [2:0] irq, input logic wr);
		@(posedge ref_clk) #1;
		tmp = rnd();
		bm = tmp[7:0] | (8'h01 << tmp[10:8]);
		k = $countones(bm);
		base = rnd();
		buffer_base_pointer = base;
		buffer_length = len;
		input_select_bitmap = bm;
		irq_condition_select = irq;
		wrap_enable = wr;
		lenv = int'(len);
		{exp_off, exp_from, n_half, n_full, n_over} = '0;
		ch_q.delete();
		res_q.delete();
		w0 = ram.n_wr;
		pulse(sb_start);
	endtask : sb_go

	// ********
	// Converter and monitors
	// ********
	always @(posedge ref_clk) begin
		#1 conv_done = 1'b0;
		if (conv_req === 1'b1 && hold == 0) begin
			cnt++;
			if (cnt == 3) begin
				tmp = rnd();
				conv_result = tmp[9:0];
				conv_done = 1'b1;
				ch_q.push_back(conv_channel);
				res_q.push_back(tmp[9:0]);
				cnt = 0;
				hold = 2;
			end
		end else if (hold > 0) hold--;
	end

	always @(posedge ref_clk) begin
		n_half += int'(half_full_irq === 1'b1);
		n_full += int'(full_irq === 1'b1);
		n_over += int'(overflow_irq === 1'b1);
		if (dma_wr_valid === 1'b1 && dma_wr_ready === 1'b1) begin
			check(16'(ch_q.pop_front()), 16'(next_ch(bm, exp_from)));
			check(dma_wr_data, {6'h00, res_q.pop_front()});
			check(dma_wr_addr, base + 16'(2 * exp_off));
			exp_from = int'(next_ch(bm, exp_from)) + 1;
			exp_off = (exp_off + 1) % lenv;
		end
	end

	// ********
	// Sequence
	// ********
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 resetn = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 check(16'(next_write_offset), 16'h0000);
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk) #1;
			buffer_length = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0800 : 16'h07FF;
			irq_condition_select = (i == 2) ? 3'h0 : 3'h7;
			input_select_bitmap = (i == 3) ? 8'h00 : 8'h81;
			ch_q.delete();
			pulse(sb_start);
			check(16'(start_rejected), 16'(i < 4));
			check(16'(sb_active), 16'(i == 4));
		end
		repeat (20) @(posedge ref_clk);
		#1 check(16'(ch_q.size()), 16'h0000);
		pulse(sb_stop);
		@(posedge ref_clk) #1 check(16'(sb_active), 16'h0000);
		slow = 1'b1;
		sb_go(16'h0005, 3'h7, 1'b0);
		for (int t = 1; t < 8; t++) begin
			pulse(sample_trigger_timer);
			wait_wr(w0 + ((k * t < 5) ? k * t : 5));
			check(16'(next_write_offset), (k * t < 5) ? 16'(k * t) : 16'h07FF);
		end
		check(16'(ram.n_wr - w0), 16'h0005);
		check(16'(n_half), 16'h0001);
		check(16'(n_full), 16'h0001);
		check(16'(n_over), 16'(7 - (5 + k - 1) / k));
		pulse(sb_stop);
		slow = 1'b0;
		sb_go(16'h0003, 3'h2, 1'b1);
		for (int t = 1; t < 4; t++) begin
			pulse(sample_trigger_timer);
			wait_wr(w0 + k * t);
		end
		check(16'(next_write_offset), 16'h0000);
		check(16'(n_full), 16'(k));
		check(16'(n_half), 16'h0000);
		pulse(sb_stop);
		pulse(sample_trigger_timer);
		wait_wr(0);
		check(16'(ram.n_wr - w0), 16'(3 * k));
		// Own copy of the settings, the converter model reuses tmp
		for (int m = 0; m < 2; m++) begin
			@(posedge ref_clk) #1;
			cfg = rnd();
			conv_source = cfg[2:0];
			input_span_select = cfg[3];
			accum_sel = 2'h3;
			conv_continuous = 1'b1;
			ch_q.delete();
			if (m == 0) pulse(conv_start);
			else pulse(accum_start);
			for (int i = 0; i < 200 && ch_q.size() < 2; i++) @(posedge ref_clk);
			#1;
			if (ch_q.size() < 2) begin
				fail_count++;
				end_sim();
			end
			check(16'(conv_span), 16'(cfg[3]));
			check(16'(conv_channel), 16'(cfg[2:0]));
			check(16'(conv_busy), 16'h0001);
			pulse(conv_disable);
			repeat (20) @(posedge ref_clk);
			#1 n = ch_q.size();
			check(16'(conv_req), 16'h0000);
			check(16'(conv_busy), 16'h0000);
			repeat (20) @(posedge ref_clk);
			#1 check(16'(ch_q.size()), 16'(n));
		end
		// Single shot and two-sample sum end by themselves
		for (int m = 0; m < 2; m++) begin
			@(posedge ref_clk) #1;
			conv_continuous = 1'b0;
			accum_sel = 2'h0;
			if (m == 0) pulse(conv_start);
			else pulse(accum_start);
			for (int i = 0; i < 200 && result_valid !== 1'b1; i++) @(posedge ref_clk) #1;
			if (result_valid !== 1'b1) begin
				fail_count++;
				end_sim();
			end
			exp16 = (m == 0) ? {6'h00, res_q[$]} : 16'(res_q[$]) + 16'(res_q[$ - 1]);
			check(result_data, exp16);
			@(posedge ref_clk) #1 check(16'(result_valid), 16'h0000);
			check(16'(conv_req), 16'h0000);
		end
		end_sim();
	end
endmodule : tb_adc_sample_buffer_dma
`default_nettype wire
